// file: design/ebcd_pkg.sv
/*
  ebcd_pkg: constants shared by the external bus configuration decoder.
  Assumes the two configuration bytes arrive as plain bytes during reset.
*/
package ebcd_pkg;
  // --------------------------------------------------------------
  // register map (apb byte addresses, one word each)
  // --------------------------------------------------------------
  localparam logic [7:0] CFG0_OFS = 8'h00;
  localparam logic [7:0] CFG1_OFS = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;
  localparam logic [7:0] ACC_OFS = 8'h0C;
  localparam logic [7:0] ACC_RES_OFS = 8'h10;
  localparam logic [7:0] FRAME_OFS = 8'h14;
  // --------------------------------------------------------------
  // configuration byte zero fields
  // --------------------------------------------------------------
  localparam int OPMAP_BIT = 0;
  localparam int ASEL_LO = 2;
  localparam int ALE_BIT = 4;
  localparam int WMAIN_LO = 5;
  // configuration byte one fields
  localparam int ALIAS_BIT = 0;
  localparam int WREG1_LO = 1;
  localparam int IFRAME_BIT = 4;
  // erased-array reset values: everything set
  localparam logic [7:0] CFG0_RST = 8'hFF;
  localparam logic [7:0] CFG1_RST = 8'hFF;
  // --------------------------------------------------------------
  // address strobe selections
  // --------------------------------------------------------------
  typedef enum logic [1:0] {
    ASEL_18 = 2'b00,
    ASEL_17 = 2'b01,
    ASEL_16 = 2'b10,
    ASEL_SPLIT = 2'b11
  } ebcd_asel_t;
  // regions
  localparam logic [7:0] REG_00 = 8'h00;
  localparam logic [7:0] REG_01 = 8'h01;
  localparam logic [7:0] REG_FE = 8'hFE;
  localparam logic [7:0] REG_FF = 8'hFF;
  localparam logic [7:0] ESC_OPCODE = 8'hA5;
  localparam logic [3:0] ESC_COL_LO = 4'h6;
  // alias window in region 00 and its source in region ff
  localparam logic [2:0] ALIAS_TOP3 = 3'b111;
  localparam logic [2:0] ALIAS_SRC3 = 3'b001;
  // timing, in oscillator periods; interrupt frame sizes in bytes
  localparam int OSC_PER_WAIT = 2;
  localparam int ALE_SHORT = 1;
  localparam int ALE_LONG = 3;
  localparam int ENDSZ_SHORT = 2;
  localparam int ENDSZ_LONG = 4;
  // loader states
  typedef enum logic [1:0] {
    LD_IDLE = 2'b00,
    LD_BYTE0 = 2'b01,
    LD_BYTE1 = 2'b10,
    LD_DONE = 2'b11
  } ebcd_ld_t;
endpackage

// file: design/ebcd_top.sv
/*
  ebcd_top: captures the two configuration bytes during reset and decodes
  external bus pin use, strobe routing, wait states, ALE width, opcode map,
  code-to-data aliasing and interrupt frame format. Access decode is
  exercised through three APB probe registers.
  Assumes CFG_RD_DATA answers the cycle after CFG_RD_REQ with the byte at
  CFG_RD_ADDR, and that APB is synchronous to REF_CLK.
*/
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ps
module ebcd_top #(
  parameter logic [23:0] CFG_ADDR = 24'hFFFFF8
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic SRST,
  // configuration source
  input wire logic EXTERNAL_ACCESS_N,
  output logic CFG_RD_REQ,
  output logic CFG_RD_EXT,
  output logic [23:0] CFG_RD_ADDR,
  input wire logic [7:0] CFG_RD_DATA,
  output logic CFG_VALID,
  // decoded bus configuration
  output logic [4:0] ADDR_LINES,
  output logic A16_PIN_ADDR,
  output logic A17_PIN_ADDR,
  output logic PORT37_FREE,
  output logic A17_PIN_FREE,
  output logic [1:0] ALE_OSC_PERIODS,
  output logic OPCODE_MAP_SELECT,
  output logic INTERRUPT_FRAME_MODE,
  output logic [2:0] FRAME_BYTES,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR
);

  // --------------------------------------------------------------
  // reset-time loader
  // --------------------------------------------------------------
  ebcd_pkg::ebcd_ld_t ld_q;
  logic [7:0] cfg0_q;
  logic [7:0] cfg1_q;
  logic ext_q;

  // bytes are read while reset is held, so the core never sees a half-set
  // configuration; first request goes out as soon as reset asserts, while the loader is idle
  always_ff @(posedge REF_CLK) begin
    if (!SRST) begin
      ld_q <= ebcd_pkg::LD_IDLE;
    end else begin
      unique case (ld_q)
        ebcd_pkg::LD_IDLE: ld_q <= ebcd_pkg::LD_BYTE0;
        ebcd_pkg::LD_BYTE0: ld_q <= ebcd_pkg::LD_BYTE1;
        ebcd_pkg::LD_BYTE1: ld_q <= ebcd_pkg::LD_DONE;
        ebcd_pkg::LD_DONE: ld_q <= ebcd_pkg::LD_DONE;
        // the loader has no power-up value; an unknown code restarts the walk
        default: ld_q <= ebcd_pkg::LD_IDLE;
      endcase
    end
  end

  // the source strap is caught by a clocked process, never by the reset
  always_ff @(posedge REF_CLK) begin
    if (SRST && ld_q == ebcd_pkg::LD_IDLE) begin
      ext_q <= !EXTERNAL_ACCESS_N;
    end
  end

  // capture happens only during reset and is frozen afterward
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      if (ld_q == ebcd_pkg::LD_BYTE0) begin
        cfg0_q <= CFG_RD_DATA;
      end
      if (ld_q == ebcd_pkg::LD_BYTE1) begin
        cfg1_q <= CFG_RD_DATA;
      end
    end
  end

  // read request: byte zero at the base, byte one at the next address
  always_comb begin
    CFG_RD_REQ = SRST && (ld_q == ebcd_pkg::LD_IDLE || ld_q == ebcd_pkg::LD_BYTE0);
    CFG_RD_ADDR = (ld_q == ebcd_pkg::LD_IDLE) ? CFG_ADDR : CFG_ADDR + 24'h000001;
    CFG_RD_EXT = !EXTERNAL_ACCESS_N;
  end

  // valid is caught on the first edge out of reset and then kept, because
  // the loader parks in idle while the core runs
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      CFG_VALID <= 1'b0;
    end else begin
      CFG_VALID <= CFG_VALID || (ld_q == ebcd_pkg::LD_DONE);
    end
  end

  // --------------------------------------------------------------
  // field decode
  // --------------------------------------------------------------
  ebcd_pkg::ebcd_asel_t asel;
  logic [1:0] wmain;
  logic [1:0] wreg1;
  logic ale_n;
  logic alias_n;

  assign asel = ebcd_pkg::ebcd_asel_t'(cfg0_q[ebcd_pkg::ASEL_LO +: 2]);
  assign wmain = cfg0_q[ebcd_pkg::WMAIN_LO +: 2];
  assign wreg1 = cfg1_q[ebcd_pkg::WREG1_LO +: 2];
  assign ale_n = cfg0_q[ebcd_pkg::ALE_BIT];
  assign alias_n = cfg1_q[ebcd_pkg::ALIAS_BIT];

  // pin use, registered so nothing glitches on the pads
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      ADDR_LINES <= 5'h10;
      A16_PIN_ADDR <= 1'b0;
      A17_PIN_ADDR <= 1'b0;
      PORT37_FREE <= 1'b1;
      A17_PIN_FREE <= 1'b1;
    end else begin
      unique case (asel)
        ebcd_pkg::ASEL_18: begin
          ADDR_LINES <= 5'h12;
          A16_PIN_ADDR <= 1'b1;
          A17_PIN_ADDR <= 1'b1;
          PORT37_FREE <= 1'b0;
          A17_PIN_FREE <= 1'b0;
        end
        ebcd_pkg::ASEL_17: begin
          ADDR_LINES <= 5'h11;
          A16_PIN_ADDR <= 1'b1;
          A17_PIN_ADDR <= 1'b0;
          PORT37_FREE <= 1'b0;
          A17_PIN_FREE <= 1'b1;
        end
        ebcd_pkg::ASEL_16: begin
          ADDR_LINES <= 5'h10;
          A16_PIN_ADDR <= 1'b0;
          A17_PIN_ADDR <= 1'b0;
          PORT37_FREE <= 1'b1;
          A17_PIN_FREE <= 1'b1;
        end
        ebcd_pkg::ASEL_SPLIT: begin
          ADDR_LINES <= 5'h10;
          A16_PIN_ADDR <= 1'b0;
          A17_PIN_ADDR <= 1'b0;
          PORT37_FREE <= 1'b0;
          A17_PIN_FREE <= 1'b1;
        end
      endcase
    end
  end

  // ale width, opcode map and interrupt frame
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      ALE_OSC_PERIODS <= 2'(ebcd_pkg::ALE_SHORT);
      OPCODE_MAP_SELECT <= 1'b1;
      INTERRUPT_FRAME_MODE <= 1'b1;
      FRAME_BYTES <= 3'(ebcd_pkg::ENDSZ_LONG);
    end else begin
      ALE_OSC_PERIODS <= ale_n ? 2'(ebcd_pkg::ALE_SHORT) : 2'(ebcd_pkg::ALE_LONG);
      OPCODE_MAP_SELECT <= cfg0_q[ebcd_pkg::OPMAP_BIT];
      INTERRUPT_FRAME_MODE <= cfg1_q[ebcd_pkg::IFRAME_BIT];
      FRAME_BYTES <= cfg1_q[ebcd_pkg::IFRAME_BIT] ? 3'(ebcd_pkg::ENDSZ_LONG)
                                                   : 3'(ebcd_pkg::ENDSZ_SHORT);
    end
  end

  // --------------------------------------------------------------
  // access probe: software writes an access, reads its decode
  // word: [23:0] address, [24] write, [25] code fetch,
  //       [31:26] are ignored; the opcode byte goes in [7:0]
  //       of the frame register instead
  // --------------------------------------------------------------
  logic [23:0] acc_addr_q;
  logic acc_wr_q;
  logic acc_code_q;
  logic [7:0] acc_op_q;
  logic [7:0] rg;
  logic [2:0] waits;
  logic [3:0] strobe_osc;
  logic rd_code;
  logic rd_data;
  logic wr_stb;
  logic on_alias;
  logic [23:0] ext_addr;
  logic need_esc;

  assign rg = acc_addr_q[23:16];

  // each code counts down from three waits to none
  always_comb begin
    if (rg == ebcd_pkg::REG_01) begin
      waits = 3'(2'b11 - wreg1);
    end else begin
      waits = 3'(2'b11 - wmain);
    end
    strobe_osc = 4'(ebcd_pkg::OSC_PER_WAIT) * {1'b0, waits} + 4'(ebcd_pkg::OSC_PER_WAIT);
  end

  // strobe routing per selection
  always_comb begin
    rd_code = 1'b0;
    rd_data = 1'b0;
    wr_stb = 1'b0;
    if (asel == ebcd_pkg::ASEL_SPLIT) begin
      rd_code = !acc_wr_q && (rg == ebcd_pkg::REG_FE || rg == ebcd_pkg::REG_FF);
      rd_data = !acc_wr_q && (rg == ebcd_pkg::REG_00 || rg == ebcd_pkg::REG_01);
      wr_stb = acc_wr_q && (rg == ebcd_pkg::REG_00 || rg == ebcd_pkg::REG_01);
    end else begin
      rd_code = !acc_wr_q;
      wr_stb = acc_wr_q;
    end
  end

  // external address: region bits folded to the lines that exist
  always_comb begin
    ext_addr = {6'h00, acc_addr_q[17:0]};
    if (asel == ebcd_pkg::ASEL_17) begin
      ext_addr = {7'h00, acc_addr_q[16:0]};
    end else if (asel == ebcd_pkg::ASEL_16 || asel == ebcd_pkg::ASEL_SPLIT) begin
      ext_addr = {8'h00, acc_addr_q[15:0]};
    end
  end

  // data access to the top of region 00 lands on on-chip code
  assign on_alias = !alias_n && !acc_code_q && rg == ebcd_pkg::REG_00
                    && acc_addr_q[15:13] == ebcd_pkg::ALIAS_TOP3;

  // escape prefix needed when the opcode column is 6H..FH and the set is
  // the one not owned by the current map
  assign need_esc = acc_op_q[3:0] >= ebcd_pkg::ESC_COL_LO
                    && (acc_code_q == !OPCODE_MAP_SELECT);

  // --------------------------------------------------------------
  // apb slave: zero wait, unmapped reads zero with error
  // --------------------------------------------------------------
  logic apb_hit;
  logic [31:0] rdata_d;

  assign PREADY = 1'b1;
  assign apb_hit = PADDR == ebcd_pkg::CFG0_OFS || PADDR == ebcd_pkg::CFG1_OFS
                   || PADDR == ebcd_pkg::STAT_OFS || PADDR == ebcd_pkg::ACC_OFS
                   || PADDR == ebcd_pkg::ACC_RES_OFS || PADDR == ebcd_pkg::FRAME_OFS;
  assign PSLVERR = PSEL && PENABLE && !apb_hit;

  // probe registers take writes in the access phase
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      acc_addr_q <= 24'h000000;
      acc_wr_q <= 1'b0;
      acc_code_q <= 1'b0;
      acc_op_q <= 8'h00;
    end else if (PSEL && PENABLE && PWRITE) begin
      if (PADDR == ebcd_pkg::ACC_OFS) begin
        acc_addr_q <= PWDATA[23:0];
        acc_wr_q <= PWDATA[24];
        acc_code_q <= PWDATA[25];
      end else if (PADDR == ebcd_pkg::FRAME_OFS) begin
        acc_op_q <= PWDATA[7:0];
      end
    end
  end

  always_comb begin
    unique case (PADDR)
      ebcd_pkg::CFG0_OFS: rdata_d = {24'h000000, cfg0_q};
      ebcd_pkg::CFG1_OFS: rdata_d = {24'h000000, cfg1_q};
      ebcd_pkg::STAT_OFS: rdata_d = {29'h00000000, ext_q, OPCODE_MAP_SELECT, CFG_VALID};
      ebcd_pkg::ACC_OFS: rdata_d = {6'h00, acc_code_q, acc_wr_q, acc_addr_q};
      ebcd_pkg::ACC_RES_OFS: rdata_d = {1'b0, on_alias, rd_code, rd_data, wr_stb, strobe_osc, waits, ext_addr[19:0]};
      // prefix flag shown twice: one extra code byte, and one state if fetched
      ebcd_pkg::FRAME_OFS: rdata_d = {22'h000000, need_esc, need_esc, acc_op_q};
      default: rdata_d = 32'h00000000;
    endcase
  end

  // read data comes from a flip-flop, loaded in the setup phase
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      PRDATA <= 32'h00000000;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      PRDATA <= rdata_d;
    end
  end

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  hold_cfg_a: assert property (@(posedge REF_CLK) disable iff (SRST)
    $stable(cfg0_q) && $stable(cfg1_q)) else $error("config changed outside reset");
  lines_18_a: assert property (@(posedge REF_CLK) disable iff (SRST)
    ##1 asel == ebcd_pkg::ASEL_18 |-> ADDR_LINES == 5'h12 && A17_PIN_ADDR) else $error("18 line decode");
  lines_17_a: assert property (@(posedge REF_CLK) disable iff (SRST)
    ##1 asel == ebcd_pkg::ASEL_17 |-> ADDR_LINES == 5'h11 && A17_PIN_FREE && !PORT37_FREE) else $error("17 line");
  split_wr_a: assert property (@(posedge REF_CLK) disable iff (SRST)
    asel == ebcd_pkg::ASEL_SPLIT && wr_stb |-> rg == ebcd_pkg::REG_00 || rg == ebcd_pkg::REG_01) else $error("write strobe");
  wait_len_a: assert property (@(posedge REF_CLK) disable iff (SRST)
    strobe_osc == 4'(2 * (32'(waits) + 1))) else $error("strobe length");
  ale_len_a: assert property (@(posedge REF_CLK) disable iff (SRST)
    ##1 !ale_n |-> ALE_OSC_PERIODS == 2'd3) else $error("ale width");
  alias_off_a: assert property (@(posedge REF_CLK) disable iff (SRST)
    alias_n |-> !on_alias) else $error("alias while disabled");
  frame_a: assert property (@(posedge REF_CLK) disable iff (SRST)
    ##1 FRAME_BYTES == (INTERRUPT_FRAME_MODE ? 3'd4 : 3'd2)) else $error("frame size");
  // load walk: ask byte zero, take it, take byte one, then park
  sequence ld_walk_s;
    ld_q == ebcd_pkg::LD_BYTE0 ##1 ld_q == ebcd_pkg::LD_BYTE1 ##1 ld_q == ebcd_pkg::LD_DONE;
  endsequence
  load_walk_a: assert property (@(posedge REF_CLK) disable iff (!SRST)
    ld_q == ebcd_pkg::LD_IDLE |=> ld_walk_s) else $error("config load walk");
  wait_sel_a: assert property (@(posedge REF_CLK) disable iff (SRST)
    rg == ebcd_pkg::REG_01 |-> waits == {1'b0, ~wreg1}) else $error("region 01 waits");
  alias_on_a: assert property (@(posedge REF_CLK) disable iff (SRST)
    on_alias |-> rg == ebcd_pkg::REG_00 && !acc_code_q) else $error("alias outside window");
  fold_17_a: assert property (@(posedge REF_CLK) disable iff (SRST)
    asel == ebcd_pkg::ASEL_17 |-> ext_addr == {7'h00, acc_addr_q[16:0]}) else $error("17 line fold");

endmodule // ebcd_top

// file: verif/ebcd_cfg_mem.sv
/*
  ebcd_cfg_mem: model of the configuration byte source, holding both the
  on-chip array and the top of external memory.
  Assumes requests come from the decoder and are answered one cycle later.
*/
`timescale 1ns/1ps
module ebcd_cfg_mem #(
  parameter logic [23:0] CFG_ADDR = 24'hFFFFF8
) (
  // clock
  input wire logic ref_clk,
  // request side
  input wire logic rd_req,
  input wire logic rd_ext,
  input wire logic [23:0] rd_addr,
  output logic [7:0] rd_data,
  // stored bytes, on-chip then external
  input wire logic [7:0] int_b0,
  input wire logic [7:0] int_b1,
  input wire logic [7:0] ext_b0,
  input wire logic [7:0] ext_b1
);
  // ----------------------------------------------------------------
  // byte answer
  // ----------------------------------------------------------------
  initial rd_data = 8'h00;
  // idle or wrong address shows a changing pattern, so a late or
  // misaddressed sample never matches by luck
  always @(posedge ref_clk) begin
    if (rd_req && rd_addr == CFG_ADDR) begin
      rd_data <= rd_ext ? ext_b0 : int_b0;
    end else if (rd_req && rd_addr == CFG_ADDR + 24'h000001) begin
      rd_data <= rd_ext ? ext_b1 : int_b1;
    end else begin
      rd_data <= ~rd_data;
    end
  end
endmodule // ebcd_cfg_mem

// file: verif/ebcd_top_tb.sv
/*
  ebcd_top_tb: loads several configurations through reset and checks the
  decoded pins and the apb view of them.
  Assumes the configuration source model and a 100 MHz clock.
*/
`timescale 1ns/1ps
module ebcd_top_tb;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic ext_n = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [7:0] ib0 = 8'hFF;
  logic [7:0] ib1 = 8'hFF;
  logic [7:0] xb0 = 8'hFF;
  logic [7:0] xb1 = 8'hFF;
  logic rd_req, rd_ext, cfg_valid, a16_addr, a17_addr, p37_free, a17_free;
  logic opmap, iframe, pready, pslverr;
  logic [23:0] rd_addr;
  logic [7:0] rd_data;
  logic [4:0] addr_lines;
  logic [1:0] ale;
  logic [2:0] frame_bytes;
  logic [31:0] prdata;
  int error_cnt = 0;
  int n_compared = 0;

  // clock: 10 ns period
  always #5 ref_clk = ~ref_clk;

  ebcd_top ebcd_top_inst (
    .REF_CLK(ref_clk), .SRST(srst), .EXTERNAL_ACCESS_N(ext_n),
    .CFG_RD_REQ(rd_req), .CFG_RD_EXT(rd_ext), .CFG_RD_ADDR(rd_addr),
    .CFG_RD_DATA(rd_data), .CFG_VALID(cfg_valid), .ADDR_LINES(addr_lines),
    .A16_PIN_ADDR(a16_addr), .A17_PIN_ADDR(a17_addr), .PORT37_FREE(p37_free),
    .A17_PIN_FREE(a17_free), .ALE_OSC_PERIODS(ale), .OPCODE_MAP_SELECT(opmap),
    .INTERRUPT_FRAME_MODE(iframe), .FRAME_BYTES(frame_bytes), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr)
  );

  ebcd_cfg_mem ebcd_cfg_mem_inst (
    .ref_clk(ref_clk), .rd_req(rd_req), .rd_ext(rd_ext), .rd_addr(rd_addr),
    .rd_data(rd_data), .int_b0(ib0), .int_b1(ib1), .ext_b0(xb0), .ext_b1(xb1)
  );

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic close_out();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // one apb transfer; entered just after a rising edge, leaves one edge
  // after release so a following call never reassigns in the same step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] d, output logic e);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    penable <= 1'b0;
    @(posedge ref_clk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never sees ready
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  // one access through the probe; strobes, waits and address follow the rules
  task automatic probe(input logic [7:0] b0, input logic [7:0] b1, input logic [23:0] a,
                       input logic wr, input logic code, input logic [7:0] op);
    logic [31:0] d;
    logic e;
    logic [7:0] rg;
    logic split;
    logic [2:0] w;
    logic [19:0] xa;
    logic escape_prefix;
    rg = a[23:16];
    split = b0[3:2] == 2'b11;
    w = {1'b0, rg == 8'h01 ? ~b1[2:1] : ~b0[6:5]};
    xa = b0[3:2] == 2'b00 ? {2'b00, a[17:0]} : b0[3:2] == 2'b01 ? {3'b000, a[16:0]} : {4'h0, a[15:0]};
    escape_prefix = op[3:0] >= 4'h6 && (b0[0] ? !code : code);
    apb(1'b1, ebcd_pkg::ACC_OFS, {6'h00, code, wr, a}, d, e);
    apb(1'b1, ebcd_pkg::FRAME_OFS, {24'h0, op}, d, e);
    apb(1'b0, ebcd_pkg::ACC_RES_OFS, 32'h0, d, e);
    chk("alias", 32'(!b1[0] && !code && rg == 8'h00 && a[15:13] == 3'b111), 32'(d[30]));
    chk("code strobe", 32'(!wr && (!split || rg >= 8'hFE)), 32'(d[29]));
    chk("data strobe", 32'(!wr && split && rg <= 8'h01), 32'(d[28]));
    chk("write strobe", 32'(wr && (!split || rg <= 8'h01)), 32'(d[27]));
    chk("strobe length", 32'(2 + 2 * w), 32'(d[26:23]));
    chk("waits", 32'(w), 32'(d[22:20]));
    chk("ext addr", 32'(xa), 32'(d[19:0]));
    apb(1'b0, ebcd_pkg::FRAME_OFS, 32'h0, d, e);
    chk("escape", {22'h0, escape_prefix, escape_prefix, op}, {22'h0, d[9:0]});
  endtask

  // load one configuration through reset, then check every decoded output
  task automatic run_cfg(input logic [7:0] b0, input logic [7:0] b1, input logic use_ext);
    logic [1:0] sel;
    logic [31:0] d;
    logic e;
    sel = b0[3:2];
    srst <= 1'b1;
    ext_n <= ~use_ext;
    // the unused source carries a different selection and ale setting
    ib0 <= use_ext ? b0 ^ 8'h1C : b0;
    ib1 <= use_ext ? ~b1 : b1;
    xb0 <= use_ext ? b0 : b0 ^ 8'h1C;
    xb1 <= use_ext ? b1 : ~b1;
    repeat (6) @(posedge ref_clk);
    chk("valid in reset", 32'd0, 32'(cfg_valid));
    repeat (6) @(posedge ref_clk);
    srst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk("valid", 32'd1, 32'(cfg_valid));
    chk("addr lines", sel == 2'b00 ? 32'd18 : sel == 2'b01 ? 32'd17 : 32'd16, 32'(addr_lines));
    chk("a16 addr", 32'(sel[1] == 1'b0), 32'(a16_addr));
    chk("a17 addr", 32'(sel == 2'b00), 32'(a17_addr));
    chk("port37 free", 32'(sel == 2'b10), 32'(p37_free));
    chk("a17 free", 32'(sel != 2'b00), 32'(a17_free));
    chk("ale", b0[4] ? 32'd1 : 32'd3, 32'(ale));
    chk("opmap", 32'(b0[0]), 32'(opmap));
    chk("frame mode", 32'(b1[4]), 32'(iframe));
    chk("frame bytes", b1[4] ? 32'd4 : 32'd2, 32'(frame_bytes));
    apb(1'b0, ebcd_pkg::CFG0_OFS, 32'h0, d, e);
    chk("byte zero", 32'(b0), {24'h0, d[7:0]});
    apb(1'b0, ebcd_pkg::CFG1_OFS, 32'h0, d, e);
    chk("byte one", 32'(b1), {24'h0, d[7:0]});
    apb(1'b0, ebcd_pkg::STAT_OFS, 32'h0, d, e);
    chk("status", {29'h0, use_ext, b0[0], 1'b1}, {29'h0, d[2:0]});
    // one access in each region kind: code read, slow-region write, alias window, top write
    probe(b0, b1, 24'hFEE123, 1'b0, 1'b1, 8'h9C);
    probe(b0, b1, 24'h01E456, 1'b1, 1'b0, 8'hA6);
    probe(b0, b1, 24'h00F00D, 1'b0, 1'b0, 8'h14);
    probe(b0, b1, 24'hFF2345, 1'b1, 1'b1, 8'h0F);
    // running changes to the source and a write to a read-only word
    ib0 <= ~ib0;
    xb0 <= ~xb0;
    apb(1'b1, ebcd_pkg::CFG0_OFS, {24'h0, ~b0}, d, e);
    apb(1'b0, ebcd_pkg::CFG0_OFS, 32'h0, d, e);
    chk("byte zero held", 32'(b0), {24'h0, d[7:0]});
    chk("lines held", sel == 2'b00 ? 32'd18 : sel == 2'b01 ? 32'd17 : 32'd16, 32'(addr_lines));
    chk("ale held", b0[4] ? 32'd1 : 32'd3, 32'(ale));
  endtask

  // ----------------------------------------------------------------
  // test sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] d;
    logic e;
    logic [1:0] k;
    for (int i = 0; i < 4; i++) begin
      k = 2'(i);
      run_cfg({1'b1, k, ~k[0], k, 1'b1, k[1]}, {3'b111, k[0] ^ k[1], 1'b1, ~k, k[0]}, k[0]);
    end
    apb(1'b0, 8'h40, 32'h0, d, e);
    chk("unmapped err", 32'd1, 32'(e));
    chk("unmapped data", 32'h0, d);
    close_out();
  end

  // the sequence needs well under 1000 cycles
  initial begin
    #100000;
    error_cnt++;
    close_out();
  end
endmodule // ebcd_top_tb
